// file: hw/interrupt_priority_resolver.sv
`timescale 1ns/100ps
module interrupt_priority_resolver (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst_n,
  input  wire logic                                clkEn,
  // Special function register port
  input  wire irq_prio_pkg::sfr_bus_s              sfrBus,
  output logic [irq_prio_pkg::SFR_DW-1:0]          sfrRdata,
  // Request sources
  input  wire logic [irq_prio_pkg::NUM_SRC-1:0]    srcSet,
  input  wire logic [irq_prio_pkg::NUM_SRC-1:0]    srcEnable,
  input  wire logic                                globalEnable,
  input  wire logic [irq_prio_pkg::NUM_SRC-1:0]    flagClear,
  // Processor core vectoring
  input  wire logic                                vectorAck,
  input  wire logic                                retiDone,
  output irq_prio_pkg::vec_req_s                   vecReq,
  // Status
  output logic [irq_prio_pkg::NUM_SRC-1:0]         requestFlags,
  output logic [irq_prio_pkg::NUM_LVL-1:0]         inServiceLevels
);

  localparam int NS = irq_prio_pkg::NUM_SRC;
  localparam int NL = irq_prio_pkg::NUM_LVL;
  localparam int LW = irq_prio_pkg::LVL_W;

  irq_prio_pkg::state_s stReg;
  irq_prio_pkg::state_s stNext;

  logic          ack;
  logic [NS-1:0] ackMask;
  logic [NS-1:0] flagsNext;
  logic [NL-1:0] svcAfterReti;
  logic [NL-1:0] svcNext;
  logic          busy;
  logic [LW-1:0] busyLevel;
  logic [NS-1:0] pendNext;
  logic [NS-1:0] cand;
  logic [LW-1:0] candLvl [NS];

  // ==========================================================================
  // Flags and service levels for the coming cycle
  assign ack     = clkEn && vectorAck && stReg.req.valid;
  assign ackMask = ack ? (NS'(1) << stReg.req.src) : '0;

  // Set wins over clear; serial bits are never held
  assign flagsNext = (stReg.flags & ~(flagClear | ackMask))
                   | (srcSet & ~irq_prio_pkg::SERIAL_MASK);
  assign pendNext  = flagsNext | (srcSet & irq_prio_pkg::SERIAL_MASK);

  always_comb begin
    svcAfterReti = stReg.inService;
    if (retiDone) begin
      for (int l = 0; l < NL; l++) begin
        if (stReg.inService[l] && ((stReg.inService >> (l + 1)) == '0)) begin
          svcAfterReti[l] = 1'b0;
        end
      end
    end
  end

  always_comb begin
    svcNext = svcAfterReti;
    if (ack) begin
      svcNext[stReg.req.level] = 1'b1;
    end
    busy      = |svcNext;
    busyLevel = '0;
    for (int l = 0; l < NL; l++) begin
      if (svcNext[l]) begin
        busyLevel = LW'(l);
      end
    end
  end

  // ==========================================================================
  // One level stage per source
  generate
    for (genvar i = 0; i < NS; i++) begin : gRank
      irq_level_rank #(.LVL_W(LW)) uRank (
        .pending   (pendNext[i]),
        .enabled   (srcEnable[i] && globalEnable),
        .lowBit    (stReg.prioLow[i / 2]),
        .highBit   (stReg.prioHigh[i / 2]),
        .busy      (busy),
        .busyLevel (busyLevel),
        .cand      (cand[i]),
        .level     (candLvl[i])
      );
    end
  endgenerate

  // ==========================================================================
  // Next state
  always_comb begin
    logic                                found;
    logic [irq_prio_pkg::SRC_W-1:0]      bestIdx;
    logic [LW-1:0]                       bestLvl;
    found   = 1'b0;
    bestIdx = '0;
    bestLvl = '0;
    stNext  = stReg;
    // Strictly greater keeps the earliest source among equals
    for (int i = 0; i < NS; i++) begin
      if (cand[i] && (!found || (candLvl[i] > bestLvl))) begin
        found   = 1'b1;
        bestIdx = irq_prio_pkg::SRC_W'(i);
        bestLvl = candLvl[i];
      end
    end
    if (clkEn) begin
      if (sfrBus.wr && (sfrBus.addr == irq_prio_pkg::PRIO_LOW_ADDR)) begin
        stNext.prioLow = sfrBus.wdata[irq_prio_pkg::NUM_GRP-1:0];
      end
      if (sfrBus.wr && (sfrBus.addr == irq_prio_pkg::PRIO_HIGH_ADDR)) begin
        stNext.prioHigh = sfrBus.wdata[irq_prio_pkg::NUM_GRP-1:0];
      end
      // Unused top bits and other addresses read as zero
      stNext.rdata = irq_prio_pkg::SFR_IDLE_DATA;
      if (sfrBus.rd) begin
        case (sfrBus.addr)
          irq_prio_pkg::PRIO_LOW_ADDR: begin
            stNext.rdata = irq_prio_pkg::SFR_DW'(stReg.prioLow);
          end
          irq_prio_pkg::PRIO_HIGH_ADDR: begin
            stNext.rdata = irq_prio_pkg::SFR_DW'(stReg.prioHigh);
          end
          default: begin
            stNext.rdata = irq_prio_pkg::SFR_IDLE_DATA;
          end
        endcase
      end
      stNext.flags     = flagsNext;
      stNext.inService = svcNext;
      stNext.req.valid = found;
      stNext.req.src   = bestIdx;
      stNext.req.level = bestLvl;
      stNext.req.addr  = irq_prio_pkg::VEC_TABLE[bestIdx];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stReg.prioLow   <= irq_prio_pkg::PRIO_RESET;
      stReg.prioHigh  <= irq_prio_pkg::PRIO_RESET;
      stReg.flags     <= irq_prio_pkg::FLAG_RESET;
      stReg.inService <= irq_prio_pkg::SVC_RESET;
      stReg.req       <= '0;
      stReg.rdata     <= irq_prio_pkg::SFR_IDLE_DATA;
    end else begin
      stReg <= stNext;
    end
  end

  assign sfrRdata        = stReg.rdata;
  assign vecReq          = stReg.req;
  assign requestFlags    = stReg.flags;
  assign inServiceLevels = stReg.inService;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk iff clkEn); endclocking
  default disable iff (!rst_n);

  property p_group_level;
    vecReq.valid |-> vecReq.level ==
      {$past(stReg.prioHigh[stNext.req.src / 2]), $past(stReg.prioLow[stNext.req.src / 2])};
  endproperty
  a_group_level: assert property (p_group_level) else $error("level not from group bits");

  property p_top_level;
    vecReq.valid && $past(stReg.prioHigh[0] && stReg.prioLow[0])
      && (vecReq.src == 4'h1) |-> vecReq.level == 2'h3;
  endproperty
  a_top_level: assert property (p_top_level) else $error("pair 11 not level 3");

  property p_sfr_rw;
    sfrBus.wr && !sfrBus.rd && (sfrBus.addr == irq_prio_pkg::PRIO_HIGH_ADDR)
      ##1 sfrBus.rd && !sfrBus.wr && (sfrBus.addr == irq_prio_pkg::PRIO_HIGH_ADDR)
      |=> sfrRdata == {2'h0, $past(sfrBus.wdata[5:0], 2)};
  endproperty
  a_sfr_rw: assert property (p_sfr_rw) else $error("priority readback wrong");

  property p_poll_first;
    $past(cand[0] && (candLvl[0] == 2'h3)) |-> vecReq.valid && (vecReq.src == 4'h0);
  endproperty
  a_poll_first: assert property (p_poll_first) else $error("polling order broken");

  property p_vec_tmr1;
    vecReq.valid && (vecReq.src == 4'h6) |-> vecReq.addr == 16'h001B;
  endproperty
  a_vec_tmr1: assert property (p_vec_tmr1) else $error("timer 1 vector wrong");

  property p_vec_ext6;
    vecReq.valid && (vecReq.src == 4'hA) |-> vecReq.addr == 16'h006B;
  endproperty
  a_vec_ext6: assert property (p_vec_ext6) else $error("line six vector wrong");

  property p_ack_clear;
    vectorAck && vecReq.valid && (vecReq.src == 4'h0) && !srcSet[0] |=> !requestFlags[0];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("flag kept after vectoring");

  property p_enabled;
    vecReq.valid |-> $past(globalEnable && srcEnable[stNext.req.src]);
  endproperty
  a_enabled: assert property (p_enabled) else $error("disabled source vectored");

  property p_preempt;
    vectorAck && vecReq.valid && !retiDone |=> inServiceLevels[$past(vecReq.level)]
      ##0 (!vecReq.valid || (vecReq.level > $past(vecReq.level)));
  endproperty
  a_preempt: assert property (p_preempt) else $error("preemption level wrong");

  c_nested: cover property (vectorAck && vecReq.valid ##[1:20] vectorAck && vecReq.valid);
  c_tie:    cover property (vecReq.valid && (vecReq.src == 4'h1) && requestFlags[3]);
  c_reti:   cover property (retiDone && (inServiceLevels != 4'h0));

endmodule

// file: hw/irq_level_rank.sv
`timescale 1ns/100ps
module irq_level_rank #(
  parameter int LVL_W = 2
) (
  // Source
  input  wire logic             pending,
  input  wire logic             enabled,
  // Group priority bits
  input  wire logic             lowBit,
  input  wire logic             highBit,
  // Running service level
  input  wire logic             busy,
  input  wire logic [LVL_W-1:0] busyLevel,
  // Result
  output logic                  cand,
  output logic [LVL_W-1:0]      level
);

  always_comb begin
    level = LVL_W'({highBit, lowBit});
    // Only a strictly higher level may interrupt a running routine
    cand  = pending && enabled && (!busy || (level > busyLevel));
  end

endmodule

// file: pkg/irq_prio_pkg.sv
package irq_prio_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_SRC = 11;
  localparam int NUM_GRP = 6;
  localparam int LVL_W   = 2;
  localparam int NUM_LVL = 4;
  localparam int SRC_W   = 4;
  localparam int VEC_W   = 16;
  localparam int SFR_AW  = 8;
  localparam int SFR_DW  = 8;

  // ==========================================================================
  // Register map
  localparam logic [SFR_AW-1:0]  PRIO_LOW_ADDR  = 8'hA9;
  localparam logic [SFR_AW-1:0]  PRIO_HIGH_ADDR = 8'hB9;
  localparam logic [NUM_GRP-1:0] PRIO_RESET     = 6'h00;
  localparam logic [SFR_DW-1:0]  SFR_IDLE_DATA  = 8'h00;

  // ==========================================================================
  // Sources, in polling order; group of a source is its index halved
  localparam int SRC_EXT0 = 0;
  localparam int SRC_SER1 = 1;
  localparam int SRC_TMR0 = 2;
  localparam int SRC_EXT2 = 3;
  localparam int SRC_EXT1 = 4;
  localparam int SRC_EXT3 = 5;
  localparam int SRC_TMR1 = 6;
  localparam int SRC_EXT4 = 7;
  localparam int SRC_SER0 = 8;
  localparam int SRC_EXT5 = 9;
  localparam int SRC_EXT6 = 10;

  // Serial channels are level requests, never held or cleared here
  localparam logic [NUM_SRC-1:0] SERIAL_MASK = 11'h102;
  localparam logic [NUM_SRC-1:0] FLAG_RESET  = 11'h000;
  localparam logic [NUM_LVL-1:0] SVC_RESET   = 4'h0;

  typedef logic [VEC_W-1:0] vec_t;
  localparam vec_t VEC_TABLE [NUM_SRC] = '{
    16'h0003, 16'h0083, 16'h000B, 16'h004B, 16'h0013, 16'h0053,
    16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h006B};

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [SFR_AW-1:0] addr;
    logic              wr;
    logic              rd;
    logic [SFR_DW-1:0] wdata;
  } sfr_bus_s;

  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] src;
    logic [LVL_W-1:0] level;
    logic [VEC_W-1:0] addr;
  } vec_req_s;

  typedef struct packed {
    logic [NUM_GRP-1:0] prioLow;
    logic [NUM_GRP-1:0] prioHigh;
    logic [NUM_SRC-1:0] flags;
    logic [NUM_LVL-1:0] inService;
    vec_req_s           req;
    logic [SFR_DW-1:0]  rdata;
  } state_s;

endpackage

// file: tb/core_model.sv
`timescale 1ns/100ps
module core_model (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Vectoring
  input  wire irq_prio_pkg::vec_req_s vecReq,
  output logic                        vectorAck,
  output logic                        retiDone,
  // Bench control
  input  wire logic                   ackOn,
  input  wire logic [1:0]             ackDly,
  input  wire logic                   retiReq,
  output logic [3:0]                  takenSrc,
  output logic [7:0]                  takenCnt
);
  // ==========================================================================
  // Core answer
  // Idle cycle after each ack, so a stale valid is never taken twice
  logic [1:0] waitCnt;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vectorAck <= 1'b0;
      retiDone <= 1'b0;
      waitCnt <= 2'h0;
      takenSrc <= 4'h0;
      takenCnt <= 8'h00;
    end else begin
      retiDone <= retiReq;
      if (vectorAck && vecReq.valid) begin
        takenSrc <= vecReq.src;
        takenCnt <= takenCnt + 8'h01;
      end
      if (vectorAck) begin
        vectorAck <= 1'b0;
      end else if (vecReq.valid && ackOn) begin
        waitCnt <= (waitCnt == ackDly) ? 2'h0 : waitCnt + 2'h1;
        vectorAck <= (waitCnt == ackDly);
      end
    end
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  // ==========================================================================
  // Signals
  logic core_clk = 0, rst_n = 0, clkEn = 1, globalEnable = 0, ackOn = 0, retiReq = 0;
  logic vectorAck, retiDone;
  logic [1:0] ackDly = 2'h0;
  logic [3:0] takenSrc;
  logic [3:0] inServiceLevels;
  logic [7:0] takenCnt, sfrRdata, seen = 8'h00, lo, hi;
  logic [10:0] srcSet = 0, srcEnable = 11'h7FF, flagClear = 0, requestFlags;
  logic [1:0] lv;
  irq_prio_pkg::sfr_bus_s sfrBus = '0;
  irq_prio_pkg::vec_req_s vecReq;
  int failures = 0, compares = 0, cycles = 0, seed = 32'h7CE51F84;
  int ord[8] = '{0, 2, 3, 4, 5, 6, 7, 9};

  interrupt_priority_resolver uut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .sfrBus(sfrBus), .sfrRdata(sfrRdata), .srcSet(srcSet), .srcEnable(srcEnable),
    .globalEnable(globalEnable), .flagClear(flagClear), .vectorAck(vectorAck),
    .retiDone(retiDone), .vecReq(vecReq), .requestFlags(requestFlags),
    .inServiceLevels(inServiceLevels));
  core_model core (.core_clk(core_clk), .rst_n(rst_n), .vecReq(vecReq),
    .vectorAck(vectorAck), .retiDone(retiDone), .ackOn(ackOn), .ackDly(ackDly),
    .retiReq(retiReq), .takenSrc(takenSrc), .takenCnt(takenCnt));

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      complete_run();
    end
  end

  // ==========================================================================
  // Expectations and checks
  function automatic logic [15:0] vec_of(input int i);
    logic [15:0] t [11] = '{16'h0003, 16'h0083, 16'h000B, 16'h004B, 16'h0013, 16'h0053,
                            16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h006B};
    return t[i];
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Drivers
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) sfrBus <= {a, 1'b1, 1'b0, d};
    @(posedge core_clk) sfrBus <= '0;
  endtask
  task automatic sfr_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk) sfrBus <= {a, 1'b0, 1'b1, 8'h00};
    @(posedge core_clk) sfrBus <= '0;
    @(negedge core_clk) chk("sfr", e, sfrRdata);
  endtask
  // Read straight after the write, so the readback sees the fresh value
  task automatic sfr_wrchk(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) sfrBus <= {a, 1'b1, 1'b0, d};
    @(posedge core_clk) sfrBus <= {a, 1'b0, 1'b1, 8'h00};
    @(posedge core_clk) sfrBus <= '0;
    @(negedge core_clk) chk("sfr", d & 8'h3F, sfrRdata);
  endtask
  // Priorities only change with interrupts off
  task automatic prog(input logic [7:0] l, input logic [7:0] h);
    @(posedge core_clk) globalEnable <= 0;
    sfr_wr(8'hA9, l);
    sfr_wrchk(8'hB9, h);
    sfr_chk(8'hA9, l & 8'h3F);
    @(posedge core_clk) globalEnable <= 1;
  endtask
  task automatic setp(input logic [10:0] m);
    @(posedge core_clk) srcSet <= m;
    @(posedge core_clk) srcSet <= m & 11'h102;
  endtask
  // A missing ack shows up as a count mismatch, not a stale match
  task automatic take(input int e);
    int n;
    n = 0;
    while (takenCnt === seen && n < 30) begin
      @(negedge core_clk);
      n++;
    end
    chk("count", 16'(seen + 8'h01), 16'(takenCnt));
    seen = takenCnt;
    chk("taken", 16'(e), 16'(takenSrc));
  endtask
  task automatic reti();
    @(posedge core_clk) retiReq <= 1;
    @(posedge core_clk) retiReq <= 0;
    repeat (2) @(negedge core_clk);
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    @(negedge core_clk) chk("valid", 0, vecReq.valid);
    chk("flags", 0, requestFlags);
    sfr_chk(8'hA9, 8'h00);
    for (int i = 0; i < 11; i++) begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      ackDly <= 2'($random(seed));
      prog(lo, hi);
      lv = {hi[i/2], lo[i/2]};
      setp(11'h001 << i);
      @(negedge core_clk) chk("valid", 1, vecReq.valid);
      chk("src", 16'(i), vecReq.src);
      chk("level", lv, vecReq.level);
      chk("vector", vec_of(i), vecReq.addr);
      chk("flag", (i == 1 || i == 8) ? 0 : 1, requestFlags[i]);
      @(posedge core_clk) ackOn <= 1;
      take(i);
      @(posedge core_clk) ackOn <= 0;
      srcSet <= 0;
      @(negedge core_clk) chk("flag", 0, requestFlags[i]);
      chk("insvc", 16'h1 << lv, inServiceLevels);
      reti();
      chk("insvc", 0, inServiceLevels);
    end
    lo = 8'($random(seed));
    prog({8{lo[0]}}, {8{lo[1]}});
    @(posedge core_clk) srcEnable <= 11'h3FF;
    ackOn <= 1;
    setp(11'h6FD);
    foreach (ord[k]) begin
      take(ord[k]);
      reti();
    end
    chk("valid", 0, vecReq.valid);
    chk("flag", 1, requestFlags[10]);
    @(posedge core_clk) flagClear <= 11'h400;
    @(posedge core_clk) flagClear <= 0;
    @(negedge core_clk) chk("flag", 0, requestFlags[10]);
    // Clock enable low: a set pulse and a write must both be lost
    @(posedge core_clk) clkEn <= 0;
    srcSet <= 11'h004;
    sfrBus <= {8'hA9, 1'b1, 1'b0, 8'h2A};
    @(posedge core_clk) srcSet <= 0;
    sfrBus <= '0;
    @(posedge core_clk) clkEn <= 1;
    srcEnable <= 11'h7FF;
    @(negedge core_clk) chk("frozen", 0, requestFlags);
    chk("valid", 0, vecReq.valid);
    sfr_chk(8'hA9, {2'h0, {6{lo[0]}}});
    prog(8'h03, 8'h02);
    sfr_chk(8'hAA, 8'h00);
    setp(11'h001);
    take(0);
    @(posedge core_clk) ackOn <= 0;
    setp(11'h010);
    repeat (3) @(negedge core_clk);
    chk("valid", 0, vecReq.valid);
    setp(11'h004);
    @(negedge core_clk) chk("src", 2, vecReq.src);
    chk("level", 3, vecReq.level);
    @(posedge core_clk) ackOn <= 1;
    take(2);
    @(negedge core_clk) chk("insvc", 16'hA, inServiceLevels);
    reti();
    chk("insvc", 16'h2, inServiceLevels);
    reti();
    take(4);
    reti();
    complete_run();
  end
endmodule
